// [rtl/pwm_interrupt_event_select.v]
`timescale 1ns/100ps
`default_nettype none
`include "pwm_evt_consts.vh"

module pwm_interrupt_event_select (
  // clock and reset
  input  wire       ref_clk,
  input  wire       nrst,
  // special function register bus
  input  wire [7:0] sfr_addr,
  input  wire [1:0] sfr_page,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  input  wire [7:0] sfr_wdata,
  output reg  [7:0] sfr_rdata,
  output reg        sfr_rvalid,
  output wire       sfr_hit,
  // pwm counter and channel outputs
  input  wire [5:0] pwm_out,
  input  wire       pwm_center_aligned,
  input  wire       pwm_period_mid,
  input  wire       pwm_period_end,
  // interrupt side
  input  wire [3:0] irq_ack,
  output reg  [3:0] irq_pulse,
  output reg  [3:0] irq_pending,
  output reg  [3:0] irq_overrun
);

  localparam NUM_INST = 4;

  // register select for one instance
  function sel_hit;
    input [7:0] addr;
    input [1:0] page;
    input integer inst;
    begin
      case (inst)
        2'h0:    sel_hit = (addr == `PWM0_EVT_ADDR) && (page == `PWM0_EVT_PAGE);
        2'h1:    sel_hit = (addr == `PWM1_EVT_ADDR) && (page == `PWM1_EVT_PAGE);
        2'h2:    sel_hit = (addr == `PWM2_EVT_ADDR) && (page == `PWM2_EVT_PAGE);
        2'h3:    sel_hit = (addr == `PWM3_EVT_ADDR) && (page == `PWM3_EVT_PAGE);
        default: sel_hit = 1'b0;
      endcase
    end
  endfunction

  // channel history
  reg  [5:0] pwm_prev_ff;
  reg        prev_valid_ff;
  wire [5:0] chan_fall;
  wire [5:0] chan_rise;

  // per-instance wiring
  wire [NUM_INST-1:0] inst_hit;
  wire [NUM_INST-1:0] inst_wr;
  wire [NUM_INST-1:0] event_hit;
  wire [31:0]         reg_bytes;
  wire [7:0]          type_bits;
  wire [11:0]         chan_bits;

  // read side and interrupt flag next state
  reg  [7:0]          nxt_rdata;
  reg  [3:0]          nxt_pending;
  reg  [3:0]          nxt_overrun;
  integer             i;

  // edge detection on the same clock, first sample not trusted
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pwm_prev_ff   <= 6'h00;
      prev_valid_ff <= 1'b0;
    end else begin
      pwm_prev_ff   <= pwm_out;
      prev_valid_ff <= 1'b1;
    end
  end

  assign chan_fall = {6{prev_valid_ff}} & pwm_prev_ff & ~pwm_out;
  assign chan_rise = {6{prev_valid_ff}} & ~pwm_prev_ff & pwm_out;

  genvar g;
  generate
    for (g = 0; g < NUM_INST; g = g + 1) begin : inst
      assign inst_hit[g] = sel_hit(sfr_addr, sfr_page, g);
      assign inst_wr[g]  = sfr_wr & inst_hit[g];

      event_select_reg u_reg (
        .ref_clk           (ref_clk),
        .nrst              (nrst),
        .wr_en             (inst_wr[g]),
        .wr_data           (sfr_wdata),
        .reg_value         (reg_bytes[g*8+7:g*8]),
        .event_type_sel    (type_bits[g*2+1:g*2]),
        .event_channel_sel (chan_bits[g*3+2:g*3])
      );

      event_detector u_det (
        .event_type_sel    (type_bits[g*2+1:g*2]),
        .event_channel_sel (chan_bits[g*3+2:g*3]),
        .chan_fall         (chan_fall),
        .chan_rise         (chan_rise),
        .period_mid        (pwm_period_mid),
        .period_end        (pwm_period_end),
        .center_aligned    (pwm_center_aligned),
        .event_hit         (event_hit[g])
      );
    end
  endgenerate

  assign sfr_hit = |inst_hit;

  // read data mux, unmapped reads return zero
  always @* begin
    nxt_rdata = 8'h00;
    for (i = 0; i < NUM_INST; i = i + 1) begin
      if (inst_hit[i]) begin
        nxt_rdata = reg_bytes[i*8 +: 8];
      end
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata  <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      sfr_rvalid <= sfr_rd;
      if (sfr_rd) begin
        sfr_rdata <= nxt_rdata;
      end
    end
  end

  // pending flags, a new event wins over an acknowledge
  always @* begin
    nxt_pending = (irq_pending & ~irq_ack) | event_hit;
    nxt_overrun = (irq_overrun & ~irq_ack) | (irq_pending & ~irq_ack & event_hit);
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_pulse   <= 4'h0;
      irq_pending <= 4'h0;
      irq_overrun <= 4'h0;
    end else begin
      irq_pulse   <= event_hit;
      irq_pending <= nxt_pending;
      irq_overrun <= nxt_overrun;
    end
  end

endmodule
`default_nettype wire

// [rtl/pwm_evt_consts.vh]
`ifndef PWM_EVT_CONSTS_VH
`define PWM_EVT_CONSTS_VH

// special function register addresses and pages
`define PWM0_EVT_ADDR      8'hB7
`define PWM0_EVT_PAGE      2'h1
`define PWM1_EVT_ADDR      8'hB6
`define PWM1_EVT_PAGE      2'h2
`define PWM2_EVT_ADDR      8'hC6
`define PWM2_EVT_PAGE      2'h2
`define PWM3_EVT_ADDR      8'hD6
`define PWM3_EVT_PAGE      2'h2

// register layout
`define EVT_REG_RESET      8'h00
`define EVT_REG_MASK       8'h37
`define EVT_TYPE_MSB       5
`define EVT_TYPE_LSB       4
`define EVT_CHAN_MSB       2
`define EVT_CHAN_LSB       0

// event type codes
`define EVT_TYPE_FALL      2'h0
`define EVT_TYPE_RISE      2'h1
`define EVT_TYPE_MID       2'h2
`define EVT_TYPE_END       2'h3

// channel codes
`define EVT_CHAN_LAST      3'h5

`endif

// [rtl/event_select_reg.v]
`timescale 1ns/100ps
`default_nettype none
`include "pwm_evt_consts.vh"

module event_select_reg (
  // clock and reset
  input  wire       ref_clk,
  input  wire       nrst,
  // write port
  input  wire       wr_en,
  input  wire [7:0] wr_data,
  // contents
  output wire [7:0] reg_value,
  output wire [1:0] event_type_sel,
  output wire [2:0] event_channel_sel
);

  reg [7:0] value_ff;

  // unused bits are never stored
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      value_ff <= `EVT_REG_RESET;
    end else if (wr_en) begin
      value_ff <= wr_data & `EVT_REG_MASK;
    end
  end

  assign reg_value         = value_ff;
  assign event_type_sel    = value_ff[`EVT_TYPE_MSB:`EVT_TYPE_LSB];
  assign event_channel_sel = value_ff[`EVT_CHAN_MSB:`EVT_CHAN_LSB];

endmodule
`default_nettype wire

// [rtl/event_detector.v]
`timescale 1ns/100ps
`default_nettype none
`include "pwm_evt_consts.vh"

module event_detector (
  // selection
  input  wire [1:0] event_type_sel,
  input  wire [2:0] event_channel_sel,
  // conditions
  input  wire [5:0] chan_fall,
  input  wire [5:0] chan_rise,
  input  wire       period_mid,
  input  wire       period_end,
  input  wire       center_aligned,
  // result
  output reg        event_hit
);

  reg [2:0] chan;

  always @* begin
    chan = event_channel_sel;
    if (event_channel_sel > `EVT_CHAN_LAST) begin
      chan = 3'h0;
    end
    case (event_type_sel)
      `EVT_TYPE_FALL: event_hit = chan_fall[chan];
      `EVT_TYPE_RISE: event_hit = chan_rise[chan];
      `EVT_TYPE_MID:  event_hit = period_mid & center_aligned;
      `EVT_TYPE_END:  event_hit = period_end & center_aligned;
      default:        event_hit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// [dv/evt_sel_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module evt_sel_monitor (
  // clock and reset
  input wire       ref_clk,
  input wire       nrst,
  // register bus
  input wire       sfr_rd,
  input wire [7:0] sfr_rdata,
  input wire       sfr_rvalid,
  // pwm side
  input wire [5:0] pwm_out,
  input wire       pwm_center_aligned,
  input wire       pwm_period_mid,
  input wire       pwm_period_end,
  // interrupt side
  input wire [3:0] irq_ack,
  input wire [3:0] irq_pulse,
  input wire [3:0] irq_pending,
  input wire [3:0] irq_overrun
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence quiet_s;
    $stable(pwm_out) && !pwm_period_mid && !pwm_period_end;
  endsequence
  chk_read_answer: assert property (sfr_rd |=> sfr_rvalid)
    else $error("read not answered");
  chk_inert_bits: assert property (sfr_rvalid |-> (sfr_rdata & 8'hC8) == 8'h00)
    else $error("inert bits read back");
  chk_quiet_none: assert property (quiet_s |=> irq_pulse == 4'h0)
    else $error("pulse without event");
  chk_edge_aligned: assert property (!pwm_center_aligned && $stable(pwm_out) |=> irq_pulse == 4'h0)
    else $error("period event in edge mode");
  chk_pulse_flag: assert property ((irq_pulse & ~irq_pending) == 4'h0)
    else $error("pulse without pending");
  chk_flag_sticky: assert property (((~irq_pending) & $past(irq_pending & ~irq_ack)) == 4'h0)
    else $error("pending lost");
  chk_ack_clears: assert property (irq_ack != 4'h0 |=> ((irq_pending ^ irq_pulse) & $past(irq_ack)) == 4'h0)
    else $error("ack did not clear");
  chk_overrun_cause: assert property ((irq_overrun & ~$past(irq_overrun | irq_pending)) == 4'h0)
    else $error("overrun without pending");
endmodule
bind pwm_interrupt_event_select evt_sel_monitor mon_u (.ref_clk, .nrst, .sfr_rd, .sfr_rdata, .sfr_rvalid,
  .pwm_out, .pwm_center_aligned, .pwm_period_mid, .pwm_period_end, .irq_ack, .irq_pulse, .irq_pending,
  .irq_overrun);
`default_nettype wire

// [dv/cpu_irq_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_irq_model (
  input wire         ref_clk,
  input wire         nrst,
  input wire         ack_en,
  input wire [3:0]   irq_pending,
  output logic [3:0] irq_ack
);
  // acknowledges each pending flag once
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) irq_ack <= 4'h0;
    else irq_ack <= ack_en ? irq_pending & ~irq_ack : 4'h0;
  end
endmodule
`default_nettype wire

// [dv/pwm_interrupt_event_select_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module pwm_interrupt_event_select_bench;
  logic       ref_clk, nrst, sfr_wr, sfr_rd, ack_en, pwm_center_aligned, pwm_period_mid, pwm_period_end;
  logic       sfr_rvalid, sfr_hit;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [1:0] sfr_page;
  logic [5:0] pwm_out;
  logic [3:0] irq_ack, irq_pulse, irq_pending, irq_overrun;
  int         err_total, cmp_count;
  logic [7:0] adr[4] = '{8'hB7, 8'hB6, 8'hC6, 8'hD6};
  logic [1:0] pg[4] = '{2'h1, 2'h2, 2'h2, 2'h2};
  pwm_interrupt_event_select dut_u (.ref_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_rvalid, .sfr_hit, .pwm_out, .pwm_center_aligned, .pwm_period_mid, .pwm_period_end,
    .irq_ack, .irq_pulse, .irq_pending, .irq_overrun);
  cpu_irq_model cpu_u (.ref_clk, .nrst, .ack_en, .irq_pending, .irq_ack);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    step;
    {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {adr[i], pg[i], d, 1'b1};
    step;
    sfr_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] p, input logic [7:0] e, input logic h);
    step;
    {sfr_addr, sfr_page, sfr_rd} = {a, p, 1'b1};
    step;
    sfr_rd = 0;
    chk("hit", {7'h0, h}, {7'h0, sfr_hit});
    chk("rvalid", 8'h01, {7'h0, sfr_rvalid});
    chk("rdata", e, sfr_rdata);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], pg[i], 8'h00, 1'b1);
      wr(i, 8'hFF);
      rd(adr[i], pg[i], 8'h37, 1'b1);
    end
    rd(8'hB7, 2'h0, 8'h00, 1'b0);
    step;
    {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {8'hB6, 2'h1, 8'h00, 1'b1};
    step;
    sfr_wr = 0;
    rd(adr[1], pg[1], 8'h37, 1'b1);
    rd(8'hB6, 2'h1, 8'h00, 1'b0);
  endtask
  task automatic t_reset;
    ack_en = 0;
    pwm_period_end = 1;
    step;
    pwm_period_end = 0;
    step;
    chk("preset", 8'h0F, {4'h0, irq_pending});
    nrst = 0;
    step;
    step;
    nrst = 1;
    ack_en = 1;
    chk("reset", 8'h00, {4'h0, irq_pending | irq_pulse | irq_overrun});
    rd(adr[0], pg[0], 8'h00, 1'b1);
  endtask
  task automatic t_edges;
    logic [2:0] s;
    for (int k = 0; k < 16; k++) begin
      s = (k % 8 > 5) ? 3'h0 : 3'(k % 8);
      wr(0, {3'h0, 1'(k / 8), 1'b0, 3'(k % 8)});
      pwm_out = (k < 8) ? 6'h3F : 6'h00;
      repeat (2) step;
      pwm_out[s] = ~pwm_out[s];
      step;
      chk("edge", 8'h01, {7'h0, irq_pulse[0]});
      pwm_out = pwm_out ^ (6'h3F & ~(6'h01 << s));
      step;
      chk("other", 8'h00, {7'h0, irq_pulse[0]});
    end
  endtask
  task automatic t_period;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) wr(i, {2'h0, 2'(2 + k % 2), 4'h5});
      pwm_center_aligned = 1'(k / 2);
      {pwm_period_mid, pwm_period_end} = (k % 2) ? 2'b01 : 2'b10;
      step;
      {pwm_period_mid, pwm_period_end} = (k % 2) ? 2'b10 : 2'b01;
      pwm_out = ~pwm_out;
      chk("point", {4'h0, {4{pwm_center_aligned}}}, {4'h0, irq_pulse});
      step;
      {pwm_period_mid, pwm_period_end} = 2'b00;
      chk("ignored", 8'h00, {4'h0, irq_pulse});
    end
  endtask
  task automatic t_flags;
    ack_en = 0;
    repeat (2) begin
      pwm_period_end = 1;
      step;
      pwm_period_end = 0;
      step;
    end
    chk("pending", 8'h0F, {4'h0, irq_pending});
    chk("overrun", 8'h0F, {4'h0, irq_overrun});
    ack_en = 1;
    repeat (3) step;
    chk("cleared", 8'h00, {4'h0, irq_pending | irq_overrun});
  endtask
  task automatic results;
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_page, sfr_wdata} = '0;
    {pwm_out, pwm_center_aligned, pwm_period_mid, pwm_period_end} = '0;
    ack_en = 1;
    repeat (6) @(posedge ref_clk);
    #1 nrst = 1;
    t_regs;
    t_edges;
    t_period;
    t_flags;
    t_reset;
    results;
  end
  initial begin
    #20000;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
